// ### rtl/arfs_ctrl.v
`include "arfs_map.vh"

module arfs_ctrl #(
    parameter WORD_W = 32
) (
    input wire mclk,
    input wire resetn,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    input wire rx_high_freq_clock,
    input wire rx_bit_clock_in,
    output wire rx_bit_clock_out,
    output wire rx_bit_clock_oe,
    input wire rx_frame_sync_in,
    output reg rx_frame_sync_out,
    output wire rx_frame_sync_oe,
    input wire serial_data_pin,
    output reg [WORD_W-1:0] rx_word,
    output reg [8:0] rx_word_slot,
    output reg rx_word_valid,
    output reg rx_frame_start
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg [31:0] fsync_ctl;
    reg [31:0] bclk_ctl;
    reg [31:0] fmt_ctl;
    reg hf_q;
    reg bclk_q;
    reg sync_q;
    reg [4:0] gen_bit;
    reg [8:0] gen_slot;
    reg receiving;
    reg [1:0] skip;
    reg [4:0] bit_idx;
    reg [8:0] slot;
    reg [WORD_W-1:0] shreg;
    reg [15:0] frame_count;
    reg [8:0] num_slots;
    reg [1:0] eff_skip;
    reg gen_level;
    wire [8:0] mode;
    wire sync_width;
    wire sync_src;
    wire sync_pol;
    wire edge_rising;
    wire bclk_src;
    wire [4:0] divide;
    wire [1:0] data_delay;
    wire [4:0] slot_last;
    wire hf_rise;
    wire div_clk;
    wire bclk_level;
    wire bclk_rise;
    wire bclk_fall;
    wire sample_pulse;
    wire drive_pulse;
    wire sync_level;
    wire frame_edge;
    wire capture;

    // ****************************************************************
    // Configuration fields
    // ****************************************************************
    assign mode = fsync_ctl[`ARFS_MODE_MSB:`ARFS_MODE_LSB];
    assign sync_width = fsync_ctl[`ARFS_WIDTH_BIT];
    assign sync_src = fsync_ctl[`ARFS_SRC_BIT];
    assign sync_pol = fsync_ctl[`ARFS_POL_BIT];
    assign edge_rising = bclk_ctl[`ARFS_EDGE_BIT];
    assign bclk_src = bclk_ctl[`ARFS_BSRC_BIT];
    assign divide = bclk_ctl[`ARFS_DIV_MSB:`ARFS_DIV_LSB];
    assign slot_last = fmt_ctl[`ARFS_SBITS_MSB:`ARFS_SBITS_LSB];
    // A reserved delay code of 3 behaves as a two bit delay
    assign data_delay = (fmt_ctl[`ARFS_DLY_MSB:`ARFS_DLY_LSB] == 2'h3) ? 2'h2 :
        fmt_ctl[`ARFS_DLY_MSB:`ARFS_DLY_LSB];

    // Slot count of one frame from the sync mode code
    always @* begin
        if (mode == `ARFS_MODE_TDM384) begin
            num_slots = `ARFS_SLOTS_384;
        end else if (mode >= `ARFS_MODE_TDM_MIN && mode <= `ARFS_MODE_TDM_MAX) begin
            num_slots = mode;
        end else begin
            num_slots = `ARFS_SLOTS_ONE;
        end
    end

    // ****************************************************************
    // Register bus
    // ****************************************************************

    // Register writes; reserved positions are masked off
    always @(posedge mclk) begin
        if (!resetn) begin
            fsync_ctl <= `ARFS_RST_FSYNC;
            bclk_ctl <= `ARFS_RST_BCLK;
            fmt_ctl <= `ARFS_RST_FMT;
        end else if (wr) begin
            if (addr == `ARFS_ADDR_FSYNC) begin
                fsync_ctl <= wdata & `ARFS_MASK_FSYNC;
            end else if (addr == `ARFS_ADDR_BCLK) begin
                bclk_ctl <= wdata & `ARFS_MASK_BCLK;
            end else if (addr == `ARFS_ADDR_FMT) begin
                fmt_ctl <= wdata & `ARFS_MASK_FMT;
            end
        end
    end

    // Read data one cycle after the read strobe, zero otherwise
    always @(posedge mclk) begin
        if (!resetn) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            if (addr == `ARFS_ADDR_FSYNC) begin
                rdata <= fsync_ctl;
            end else if (addr == `ARFS_ADDR_BCLK) begin
                rdata <= bclk_ctl;
            end else if (addr == `ARFS_ADDR_FMT) begin
                rdata <= fmt_ctl;
            end else if (addr == `ARFS_ADDR_STAT) begin
                rdata <= {frame_count, 6'h00, receiving, slot};
            end else if (addr == `ARFS_ADDR_WORD) begin
                rdata <= rx_word;
            end else begin
                rdata <= 32'h00000000;
            end
        end else begin
            rdata <= 32'h00000000;
        end
    end

    // ****************************************************************
    // Bit clock selection and edges
    // ****************************************************************

    // Rising edges of the high frequency clock feed the divider
    always @(posedge mclk) begin
        if (!resetn) begin
            hf_q <= 1'b0;
        end else begin
            hf_q <= rx_high_freq_clock;
        end
    end
    assign hf_rise = rx_high_freq_clock & ~hf_q;

    arfs_bitclk_div u_div (
        .mclk(mclk),
        .resetn(resetn),
        .hf_level(rx_high_freq_clock),
        .hf_rise(hf_rise),
        .divide(divide),
        .bitclk(div_clk)
    );

    // Pin drive only when the clock is made internally
    assign rx_bit_clock_out = div_clk;
    assign rx_bit_clock_oe = bclk_src;
    assign bclk_level = bclk_src ? div_clk : rx_bit_clock_in;

    // Edge detection of the selected bit clock
    always @(posedge mclk) begin
        if (!resetn) begin
            bclk_q <= 1'b0;
        end else begin
            bclk_q <= bclk_level;
        end
    end
    assign bclk_rise = bclk_level & ~bclk_q;
    assign bclk_fall = ~bclk_level & bclk_q;
    // Sample on the chosen edge; drive our own sync on the other
    assign sample_pulse = edge_rising ? bclk_rise : bclk_fall;
    assign drive_pulse = edge_rising ? bclk_fall : bclk_rise;

    // ****************************************************************
    // Internal frame sync generator
    // ****************************************************************

    // Bit and slot counters advance on the drive edge
    always @(posedge mclk) begin
        if (!resetn) begin
            gen_bit <= 5'h00;
            gen_slot <= 9'h000;
        end else if (!sync_src) begin
            gen_bit <= 5'h00;
            gen_slot <= 9'h000;
        end else if (drive_pulse) begin
            if (gen_bit >= slot_last) begin
                gen_bit <= 5'h00;
                if (gen_slot >= num_slots - 9'h001) begin
                    gen_slot <= 9'h000;
                end else begin
                    gen_slot <= gen_slot + 9'h001;
                end
            end else begin
                gen_bit <= gen_bit + 5'h01;
            end
        end
    end

    // Sync is active in slot zero, for one bit or the whole word
    always @* begin
        gen_level = (gen_slot == 9'h000) && (sync_width || gen_bit == 5'h00);
    end

    // Output level follows the polarity; updated on drive edges
    always @(posedge mclk) begin
        if (!resetn) begin
            rx_frame_sync_out <= 1'b0;
        end else if (!sync_src) begin
            rx_frame_sync_out <= sync_pol;
        end else if (drive_pulse) begin
            rx_frame_sync_out <= gen_level ^ sync_pol;
        end
    end
    assign rx_frame_sync_oe = sync_src;

    // ****************************************************************
    // Frame start detection
    // ****************************************************************

    // The sync is seen at sample edges from the pin or our own output
    assign sync_level = sync_src ? rx_frame_sync_out : rx_frame_sync_in;

    always @(posedge mclk) begin
        if (!resetn) begin
            sync_q <= 1'b0;
        end else if (sample_pulse) begin
            sync_q <= sync_level;
        end
    end

    // Rising edge starts a frame, or falling when polarity is set
    assign frame_edge = sample_pulse &&
        (sync_pol ? (sync_q && !sync_level) : (!sync_q && sync_level));

    // ****************************************************************
    // Data delay and word assembly
    // ****************************************************************

    // Remaining skip bits, freshly loaded at a frame start
    always @* begin
        eff_skip = frame_edge ? data_delay : skip;
    end
    assign capture = sample_pulse && (receiving || frame_edge) && (eff_skip == 2'h0);

    // Shift data MSB first, slot by slot, until the frame ends
    always @(posedge mclk) begin
        if (!resetn) begin
            receiving <= 1'b0;
            skip <= 2'h0;
            bit_idx <= 5'h00;
            slot <= 9'h000;
            shreg <= {WORD_W{1'b0}};
            rx_word <= {WORD_W{1'b0}};
            rx_word_slot <= 9'h000;
            rx_word_valid <= 1'b0;
            rx_frame_start <= 1'b0;
            frame_count <= 16'h0000;
        end else begin
            rx_word_valid <= 1'b0;
            rx_frame_start <= frame_edge;
            if (frame_edge) begin
                receiving <= 1'b1;
                bit_idx <= 5'h00;
                slot <= 9'h000;
                frame_count <= frame_count + 16'h0001;
            end
            if (sample_pulse && (receiving || frame_edge) && eff_skip != 2'h0) begin
                skip <= eff_skip - 2'h1;
            end else if (frame_edge) begin
                skip <= 2'h0;
            end
            if (capture) begin
                shreg <= {shreg[WORD_W-2:0], serial_data_pin};
                if ((frame_edge ? 5'h00 : bit_idx) >= slot_last) begin
                    bit_idx <= 5'h00;
                    rx_word <= {shreg[WORD_W-2:0], serial_data_pin};
                    rx_word_slot <= frame_edge ? 9'h000 : slot;
                    rx_word_valid <= 1'b1;
                    if ((frame_edge ? 9'h000 : slot) >= num_slots - 9'h001) begin
                        receiving <= 1'b0;
                        slot <= 9'h000;
                    end else begin
                        slot <= (frame_edge ? 9'h000 : slot) + 9'h001;
                    end
                end else begin
                    bit_idx <= (frame_edge ? 5'h00 : bit_idx) + 5'h01;
                end
            end
        end
    end
endmodule // arfs_ctrl

// ### rtl/arfs_map.vh
`ifndef ARFS_MAP_VH
`define ARFS_MAP_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ARFS_ADDR_FSYNC 8'h00
`define ARFS_ADDR_BCLK 8'h04
`define ARFS_ADDR_FMT 8'h08
`define ARFS_ADDR_STAT 8'h0C
`define ARFS_ADDR_WORD 8'h10

// ****************************************************************
// Writable bit masks, reserved bits stay zero
// ****************************************************************
`define ARFS_MASK_FSYNC 32'h0000FF93
`define ARFS_MASK_BCLK 32'h000000BF
`define ARFS_MASK_FMT 32'h000001F3

// ****************************************************************
// Reset values
// ****************************************************************
`define ARFS_RST_FSYNC 32'h00000000
`define ARFS_RST_BCLK 32'h00000000
`define ARFS_RST_FMT 32'h000001F0

// ****************************************************************
// Field positions of the frame sync control register
// ****************************************************************
`define ARFS_MODE_MSB 15
`define ARFS_MODE_LSB 7
`define ARFS_WIDTH_BIT 4
`define ARFS_SRC_BIT 1
`define ARFS_POL_BIT 0

// ****************************************************************
// Field positions of the bit clock control register
// ****************************************************************
`define ARFS_EDGE_BIT 7
`define ARFS_BSRC_BIT 5
`define ARFS_DIV_MSB 4
`define ARFS_DIV_LSB 0

// ****************************************************************
// Field positions of the format register
// ****************************************************************
`define ARFS_DLY_MSB 1
`define ARFS_DLY_LSB 0
`define ARFS_SBITS_MSB 8
`define ARFS_SBITS_LSB 4

// ****************************************************************
// Sync mode codes and slot counts
// ****************************************************************
`define ARFS_MODE_BURST 9'h000
`define ARFS_MODE_TDM_MIN 9'h002
`define ARFS_MODE_TDM_MAX 9'h020
`define ARFS_MODE_TDM384 9'h180
`define ARFS_SLOTS_384 9'h180
`define ARFS_SLOTS_ONE 9'h001

`endif

// ### rtl/arfs_bitclk_div.v
// ****************************************************************
// Internal bit clock divider
// ****************************************************************
module arfs_bitclk_div (
    input wire mclk,
    input wire resetn,
    input wire hf_level,
    input wire hf_rise,
    input wire [4:0] divide,
    output wire bitclk
);
    reg [4:0] count;
    reg div_q;
    wire [4:0] half;

    // High phase length, ratio is divide plus one
    assign half = (divide >> 1) + 5'h01;

    // Count high clock rising edges and shape the divided clock
    always @(posedge mclk) begin
        if (!resetn) begin
            count <= 5'h00;
            div_q <= 1'b1;
        end else if (hf_rise) begin
            if (count >= divide) begin
                count <= 5'h00;
                div_q <= 1'b1;
            end else begin
                count <= count + 5'h01;
                div_q <= ((count + 5'h01) < half);
            end
        end
    end

    // Divide by one passes the high clock straight through
    assign bitclk = (divide == 5'h00) ? hf_level : div_q;
endmodule // arfs_bitclk_div

// ### verification/arfs_checker.sv
`include "arfs_map.vh"

// ************
// Port checker
// ************
module arfs_checker (
    input wire mclk,
    input wire resetn,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    input wire rx_high_freq_clock,
    input wire rx_bit_clock_out,
    input wire rx_bit_clock_oe,
    input wire rx_frame_sync_oe,
    input wire rx_word_valid,
    input wire rx_frame_start
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [4:0] div_m;
    // Mirror of the divide field, updated with the register
    always @(posedge mclk) begin
        if (!resetn)
            div_m <= 5'h00;
        else if (wr && addr == `ARFS_ADDR_BCLK)
            div_m <= wdata[4:0];
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    rd_idle_a: assert property (!rd |=> rdata == 32'h0)
        else $error("read data not zero outside a read");
    fs_resv_a: assert property (rd && addr == `ARFS_ADDR_FSYNC |=>
        (rdata & ~`ARFS_MASK_FSYNC) == 32'h0) else $error("sync reg reserved bits set");
    bc_resv_a: assert property (rd && addr == `ARFS_ADDR_BCLK |=>
        (rdata & ~`ARFS_MASK_BCLK) == 32'h0) else $error("clock reg reserved bits set");
    fs_oe_a: assert property (wr && addr == `ARFS_ADDR_FSYNC |=>
        rx_frame_sync_oe == $past(wdata[1])) else $error("sync enable wrong");
    bc_oe_a: assert property (wr && addr == `ARFS_ADDR_BCLK |=>
        rx_bit_clock_oe == $past(wdata[5])) else $error("bit clock enable wrong");
    pass_thru_a: assert property (div_m == 5'h00 |->
        rx_bit_clock_out == rx_high_freq_clock) else $error("no pass through");
    start_pulse_a: assert property (rx_frame_start |=> !rx_frame_start)
        else $error("frame start longer than one cycle");
    valid_pulse_a: assert property (rx_word_valid |=> !rx_word_valid)
        else $error("word valid longer than one cycle");
endmodule // arfs_checker

bind arfs_ctrl arfs_checker u_chk (.mclk(mclk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rx_high_freq_clock(rx_high_freq_clock), .rx_bit_clock_out(rx_bit_clock_out),
    .rx_bit_clock_oe(rx_bit_clock_oe), .rx_frame_sync_oe(rx_frame_sync_oe),
    .rx_word_valid(rx_word_valid), .rx_frame_start(rx_frame_start));

// ### verification/arfs_tx_model.sv
// ******************
// Serial transmitter
// ******************
module arfs_tx_model (
    input wire mclk,
    input wire edge_sel,
    input wire pol,
    input wire [1:0] dly,
    input wire [15:0] frame,
    input wire go,
    output logic bclk,
    output logic fsync,
    output logic sdata,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    int i;
    initial begin
        bclk = 1'b0;
        fsync = 1'b0;
        sdata = 1'b0;
        busy = 1'b0;
    end
    // One frame of two slots per go; clock stands still between frames
    always begin
        @(posedge mclk);
        if (go) begin
            busy <= 1'b1;
            bclk <= edge_sel;
            fsync <= pol;
            repeat (4) @(posedge mclk);
            for (i = 0; i < 18; i++) begin
                bclk <= ~edge_sel; // Launch edge opposite the sampling edge
                fsync <= (i == 0) ^ pol;
                if (i >= dly && i < dly + 16)
                    sdata <= frame[15 - (i - dly)];
                else
                    sdata <= ~sdata; // Released line shows no stale bit
                repeat (4) @(posedge mclk);
                bclk <= edge_sel;
                repeat (4) @(posedge mclk);
            end
            busy <= 1'b0;
        end
    end
endmodule // arfs_tx_model

// ### verification/tb.sv
`include "arfs_map.vh"

// *********
// Testbench
// *********
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, resetn = 0, wr = 0, rd = 0, go = 0, edge_sel = 0, pol = 0;
    logic [1:0] hc = 0, dly = 0;
    logic [7:0] addr = 0;
    logic [31:0] wdata = 0, rdata, rx_word;
    logic [15:0] frame = 0, prevf = 0;
    logic [8:0] rx_word_slot;
    logic bc_out, bc_oe, fs_out, fs_oe, m_bc, m_fs, m_sd, busy, rx_word_valid, rx_frame_start;
    logic [7:0] wq[$];
    logic [8:0] sq[$];
    int error_cnt = 0, checks = 0, nfs = 0, per, hi, k;
    logic [8:0] modes[4] = '{9'h000, 9'h002, 9'h020, 9'h180};
    logic [4:0] divs[3] = '{5'h00, 5'h02, 5'h1F};
    logic [11:0] syc[3] = '{12'h020, 12'h028, 12'h049};
    logic [3:0] rxc[4] = '{4'b0000, 4'b1101, 4'b0110, 4'b1000};

    arfs_ctrl DUT (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .rx_high_freq_clock(hc[1]),
        .rx_bit_clock_in(bc_oe ? bc_out : m_bc), .rx_bit_clock_out(bc_out),
        .rx_bit_clock_oe(bc_oe), .rx_frame_sync_in(fs_oe ? fs_out : m_fs),
        .rx_frame_sync_out(fs_out), .rx_frame_sync_oe(fs_oe), .serial_data_pin(m_sd),
        .rx_word(rx_word), .rx_word_slot(rx_word_slot), .rx_word_valid(rx_word_valid),
        .rx_frame_start(rx_frame_start));
    arfs_tx_model u_tx (.mclk(mclk), .edge_sel(edge_sel), .pol(pol), .dly(dly),
        .frame(frame), .go(go), .bclk(m_bc), .fsync(m_fs), .sdata(m_sd), .busy(busy));

    // Clock and high clock at a quarter of its rate
    always #50 mclk = ~mclk;
    always @(posedge mclk) hc <= hc + 2'h1;
    // Collects received words and frame starts
    always @(negedge mclk) begin
        if (rx_word_valid === 1'b1) begin
            wq.push_back(rx_word[7:0]);
            sq.push_back(rx_word_slot);
        end
        if (rx_frame_start === 1'b1) nfs++;
    end

    task cmp(input string nm, input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, want, got);
        end
    endtask
    task reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task reg_rd(input logic [7:0] a, input logic [31:0] want);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        cmp("rdata", rdata, want);
    endtask
    // Rise to rise period and high time of bit clock (s=0) or sync (s=1)
    task meas(input bit s);
        int n;
        logic p, c;
        n = 0;
        per = -1;
        hi = 0;
        p = 1'b1;
        while (n < 3000) begin
            @(negedge mclk);
            n++;
            c = s ? fs_out : bc_out;
            if (c === 1'b1 && p === 1'b0) begin
                if (per >= 0) break;
                per = 0;
            end
            if (per >= 0) per += 1;
            if (per >= 0 && c === 1'b1) hi += 1;
            p = c;
        end
    endtask
    task complete_run;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog
    initial begin
        #3000000;
        error_cnt++;
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        reg_rd(`ARFS_ADDR_FSYNC, `ARFS_RST_FSYNC);
        reg_rd(`ARFS_ADDR_BCLK, `ARFS_RST_BCLK);
        reg_rd(`ARFS_ADDR_FMT, `ARFS_RST_FMT);
        reg_wr(`ARFS_ADDR_FSYNC, 32'hFFFFFFFF);
        reg_rd(`ARFS_ADDR_FSYNC, `ARFS_MASK_FSYNC);
        reg_wr(`ARFS_ADDR_BCLK, 32'hFFFFFFFF);
        reg_rd(`ARFS_ADDR_BCLK, `ARFS_MASK_BCLK);
        reg_wr(8'h20, 32'hFFFFFFFF);
        reg_rd(8'h20, 32'h00000000);
        for (k = 0; k < 4; k++) begin
            reg_wr(`ARFS_ADDR_FSYNC, {16'h0, modes[k], 7'h00});
            reg_rd(`ARFS_ADDR_FSYNC, {16'h0, modes[k], 7'h00});
        end
        for (k = 0; k < 3; k++) begin
            reg_wr(`ARFS_ADDR_BCLK, {27'h1, divs[k]});
            meas(0);
            meas(0);
            cmp("bit clock period", per, 4 * (divs[k] + 1));
            cmp("bit clock enable", bc_oe, 1);
        end
        reg_wr(`ARFS_ADDR_FMT, 32'h00000070);
        // Internal bit clock of eight cycles: divide by two of the high clock
        reg_wr(`ARFS_ADDR_BCLK, 32'h00000021);
        for (k = 0; k < 3; k++) begin
            reg_wr(`ARFS_ADDR_FSYNC, {16'h0, 1'h0, syc[k][11:4], 2'h0, syc[k][3], 2'h0, 1'h1,
                syc[k][0]});
            meas(1);
            meas(1);
            // Eight bits of eight cycles per slot
            cmp("sync period", per, syc[k][11:4] * 64);
            cmp("sync high", hi, syc[k][0] ? syc[k][11:4] * 64 - (syc[k][3] ? 64 : 8) :
                (syc[k][3] ? 64 : 8));
            cmp("sync enable", fs_oe, 1);
        end
        // Second reset clears receive state left over from the sync tests
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        reg_rd(`ARFS_ADDR_FSYNC, `ARFS_RST_FSYNC);
        for (k = 0; k < 4; k++) begin
            {edge_sel, pol, dly} = rxc[k];
            frame = {8'hA5 ^ k[7:0], 8'h3C + k[7:0]};
            reg_wr(`ARFS_ADDR_BCLK, {24'h0, edge_sel, 7'h00});
            reg_wr(`ARFS_ADDR_FSYNC, {23'h0, 9'h100 | pol});
            reg_wr(`ARFS_ADDR_FMT, {24'h0, 6'h1C, dly});
            wq.delete();
            sq.delete();
            nfs = 0;
            go <= 1'b1;
            @(posedge mclk);
            go <= 1'b0;
            repeat (2) @(posedge mclk);
            while (busy === 1'b1) @(posedge mclk);
            repeat (10) @(posedge mclk);
            cmp("word count", wq.size(), 2);
            cmp("frame starts", nfs, 1);
            if (wq.size() == 2) begin
                cmp("slot 0 word", wq[0], frame[15:8]);
                cmp("slot 1 word", wq[1], frame[7:0]);
                cmp("slot index", {sq[0], sq[1]}, 18'h00001);
            end
            // Word register keeps shifting across frames since the reset
            reg_rd(`ARFS_ADDR_WORD, {prevf, frame});
            reg_rd(`ARFS_ADDR_STAT, {k[15:0] + 16'h1, 16'h0});
            prevf = frame;
        end
        complete_run();
    end
endmodule // tb
